// ### hw/lamp_addr_target.sv
// Serial target front end: address decode, command byte and register pointer
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Ten-pin build takes address from two pins; eight-pin build uses fixed address.
// - Address byte bit zero: one means read, zero means write.
// - Broadcast address resets to E0h, enabled, acked for E0h and E1h.
// - Group addresses reset to E2h, E4h, E8h and are rewritable.
// - Group addresses are disabled after reset and get no acknowledge.
// - Reset call 06h acked only with write direction.
// - After an acked write address other than the reset call the next byte becomes the command byte.
// - Command low four bits are pointer, upper three bits increment option.
// - Reset call transactions never load or use the command byte.
// - With increment flag set, pointer advances after every data byte.
// - Option 100 steps through all registers, wrapping 1100 to 0000.
// - Option 101 cycles brightness registers, wrapping 0101 to 0010.
// - Option 110 cycles global registers, wrapping 0111 to 0110.
// - Option 111 cycles brightness and global, wrapping 0111 to 0010.
// - Option 000 keeps pointer fixed across data bytes.
// - Increment changes only the pointer bits, never the option bits.
// - First data byte uses the written pointer, 0000 to 1100.
// - Pointer above its window runs to 1100, wraps to 0000, then loops.
// - Otherwise reserved bus addresses are matched like any regular address.
// - Command pointers 1101 to 1111 are not acknowledged.
// - Each group and broadcast match is gated by its own enable bit.
module lamp_addr_target #(
    parameter bit         TEN_PIN    = 1'b1,
    parameter logic [4:0] ADDR_UPPER = 5'h18,   // Upper bits for the pin-select build
    parameter logic [6:0] ADDR_FIXED = 7'h62    // Whole address for the fixed build
) (
    input  wire logic                   mclk,
    input  wire logic                   resetn,
    input  wire logic                   scl,
    input  wire logic                   sda_i,
    output logic                        sda_o,
    output logic                        sda_oe,
    input  wire logic                   hw_addr_select_pin_lo,
    input  wire logic                   hw_addr_select_pin_hi,
    input  wire logic [7:0]             reg_rdata,
    output logic [3:0]                  reg_rd_index,
    output lamp_addr_pkg::reg_wr_s      reg_wr,
    output logic [7:0]                  command_pointer_register,
    output logic                        soft_reset_call
);
    import lamp_addr_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_ACK, ST_RDATA,
                              ST_MACK} bus_state_e;

    bus_state_e  state_q;
    bus_state_e  after_q;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  cnt_q;
    logic [7:0]  shift_q;
    logic        full_q;
    logic        oe_q;
    logic        sda_low_q;
    logic        mack_q;
    logic [7:0]  cmd_q;
    logic [3:0]  en_q;
    logic [7:0]  grp1_q;
    logic [7:0]  grp2_q;
    logic [7:0]  grp3_q;
    logic [7:0]  bcast_q;
    reg_wr_s     wr_q;
    logic        srst_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_w;
    logic        stop_w;
    logic        byte_end;
    logic [6:0]  own_addr;
    logic        soft_reset_call_w;
    logic        addr_hit;
    logic        ack_now;
    bus_state_e  nxt_w;
    logic        rd_load;
    logic        wr_end;
    logic        adv_w;
    logic [7:0]  rd_byte;

    // ------------------------------------------------------------------
    // Pointer stepping
    // ------------------------------------------------------------------
    // A pointer past the window first runs out to the top, then loops inside
    function automatic logic [3:0] next_ptr(input logic [3:0] p, input logic [2:0] ai);
        logic [3:0] r;
        r = p;
        if (ai[2])
        begin
            if (p >= PTR_LAST)
                r = PTR_ALL_FIRST;
            else if (ai == INCR_BRIGHT && p == PTR_BRIGHT_LAST)
                r = PTR_BRIGHT_FIRST;
            else if (ai == INCR_GLOBAL && p == PTR_GLOBAL_LAST)
                r = PTR_GLOBAL_FIRST;
            else if (ai == INCR_MIXED && p == PTR_GLOBAL_LAST)
                r = PTR_BRIGHT_FIRST;
            else
                r = p + 4'h1;
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Bus event detection
    // ------------------------------------------------------------------
    // Pins are already synchronous, so one stage of history is enough
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda_i;
        end
    end

    assign scl_rise = scl && !scl_q;
    assign scl_fall = !scl && scl_q;
    assign start_w  = scl && scl_q && sda_q && !sda_i;
    assign stop_w   = scl && scl_q && !sda_q && sda_i;
    assign byte_end = scl_fall && full_q;

    // ------------------------------------------------------------------
    // Address decode and acknowledge decision
    // ------------------------------------------------------------------
    assign own_addr = TEN_PIN ? {ADDR_UPPER, hw_addr_select_pin_hi, hw_addr_select_pin_lo}
                              : ADDR_FIXED;
    assign soft_reset_call_w  = (shift_q == SOFT_RST_BYTE);
    // No reserved address is filtered: the plain compare treats them all alike
    assign addr_hit = (shift_q[7:1] == own_addr)
                   || (en_q[EN_BCAST_BIT] && shift_q[7:1] == bcast_q[7:1])
                   || (en_q[EN_GRP1_BIT] && shift_q[7:1] == grp1_q[7:1])
                   || (en_q[EN_GRP2_BIT] && shift_q[7:1] == grp2_q[7:1])
                   || (en_q[EN_GRP3_BIT] && shift_q[7:1] == grp3_q[7:1])
                   || soft_reset_call_w;

    // Decision taken on the falling clock that ends a byte
    always_comb
    begin
        ack_now = 1'b0;
        nxt_w   = ST_IDLE;
        case (state_q)
            ST_ADDR:
            begin
                ack_now = addr_hit;
                if (shift_q[0])
                    nxt_w = ST_RDATA;
                else if (soft_reset_call_w)
                    nxt_w = ST_IDLE;
                else
                    nxt_w = ST_CMD;
            end
            ST_CMD:
            begin
                ack_now = (shift_q[3:0] <= PTR_LAST);
                nxt_w   = ST_WDATA;
            end
            ST_WDATA:
            begin
                ack_now = 1'b1;
                nxt_w   = ST_WDATA;
            end
            default:
            begin
                ack_now = 1'b0;
                nxt_w   = ST_IDLE;
            end
        endcase
    end

    assign rd_load = scl_fall && ((state_q == ST_ACK && after_q == ST_RDATA)
                               || (state_q == ST_MACK && mack_q));
    assign wr_end  = (state_q == ST_WDATA) && byte_end;
    assign adv_w   = rd_load || wr_end;

    // Read source: locally held registers, otherwise the outside register file
    always_comb
    begin
        case (cmd_q[3:0])
            IDX_MODE1: rd_byte = {cmd_q[7:5], reg_rdata[SLEEP_BIT], en_q};
            IDX_GRP1:  rd_byte = grp1_q;
            IDX_GRP2:  rd_byte = grp2_q;
            IDX_GRP3:  rd_byte = grp3_q;
            IDX_BCAST: rd_byte = bcast_q;
            default:   rd_byte = reg_rdata;
        endcase
    end

    // ------------------------------------------------------------------
    // Bit level state machine
    // ------------------------------------------------------------------
    // Start and stop override any state, so a broken transfer always recovers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= ST_IDLE;
            after_q <= ST_IDLE;
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
            full_q  <= 1'b0;
            oe_q    <= 1'b0;
            mack_q  <= 1'b0;
        end
        else if (start_w)
        begin
            state_q <= ST_ADDR;
            cnt_q   <= 4'h0;
            full_q  <= 1'b0;
            oe_q    <= 1'b0;
        end
        else if (stop_w)
        begin
            state_q <= ST_IDLE;
            oe_q    <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_ADDR, ST_CMD, ST_WDATA:
                begin
                    if (scl_rise && !full_q)
                    begin
                        shift_q <= {shift_q[6:0], sda_i};
                        cnt_q   <= cnt_q + 4'h1;
                        full_q  <= (cnt_q == 4'h7);
                    end
                    else if (byte_end)
                    begin
                        full_q  <= 1'b0;
                        cnt_q   <= 4'h0;
                        oe_q    <= ack_now;
                        after_q <= nxt_w;
                        state_q <= ack_now ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK, ST_MACK:
                begin
                    if (scl_rise && state_q == ST_MACK)
                        mack_q <= !sda_i;
                    if (rd_load)
                    begin
                        oe_q    <= !rd_byte[7];
                        shift_q <= {rd_byte[6:0], 1'b0};
                        cnt_q   <= 4'h1;
                        state_q <= ST_RDATA;
                    end
                    else if (scl_fall)
                    begin
                        oe_q    <= 1'b0;
                        state_q <= (state_q == ST_ACK) ? after_q : ST_IDLE;
                    end
                end
                ST_RDATA:
                begin
                    if (scl_fall && cnt_q == 4'h8)
                    begin
                        oe_q    <= 1'b0;
                        mack_q  <= 1'b0;
                        state_q <= ST_MACK;
                    end
                    else if (scl_fall)
                    begin
                        oe_q    <= !shift_q[7];
                        shift_q <= {shift_q[6:0], 1'b0};
                        cnt_q   <= cnt_q + 4'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Command byte and pointer
    // ------------------------------------------------------------------
    // Only a non-reset write leads to ST_CMD, and the pointer survives stops
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            cmd_q <= CMD_RST;
        else if (state_q == ST_CMD && byte_end && ack_now)
            cmd_q <= shift_q;
        else if (adv_w)
            cmd_q[3:0] <= next_ptr(cmd_q[3:0], cmd_q[7:5]);
    end

    // ------------------------------------------------------------------
    // Locally held enables and call addresses
    // ------------------------------------------------------------------
    // Option bits of the mode register are read only, so only enables store
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_q    <= MODE1_EN_RST;
            grp1_q  <= GRP1_RST;
            grp2_q  <= GRP2_RST;
            grp3_q  <= GRP3_RST;
            bcast_q <= BCAST_RST;
        end
        else if (wr_end)
        begin
            case (cmd_q[3:0])
                IDX_MODE1: en_q    <= shift_q[3:0];
                IDX_GRP1:  grp1_q  <= shift_q;
                IDX_GRP2:  grp2_q  <= shift_q;
                IDX_GRP3:  grp3_q  <= shift_q;
                IDX_BCAST: bcast_q <= shift_q;
                default:   en_q    <= en_q;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outward strobes
    // ------------------------------------------------------------------
    // One-cycle pulses; the register file must take them in that cycle
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_q      <= '0;
            srst_q    <= 1'b0;
            sda_low_q <= 1'b0;
        end
        else
        begin
            wr_q.strobe <= wr_end;
            wr_q.index  <= cmd_q[3:0];
            wr_q.data   <= shift_q;
            srst_q      <= (state_q == ST_ADDR) && byte_end && soft_reset_call_w;
            sda_low_q   <= 1'b0;   // Open drain: only ever pulls low
        end
    end

    assign sda_o                    = sda_low_q;
    assign sda_oe                   = oe_q;
    assign reg_rd_index             = cmd_q[3:0];
    assign reg_wr                   = wr_q;
    assign command_pointer_register = cmd_q;
    assign soft_reset_call          = srst_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_hold_off;
        adv_w && !cmd_q[7] |=> $stable(cmd_q[3:0]);
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("pointer moved with increment off");

    property p_wrap_all;
        adv_w && cmd_q[3:0] == PTR_LAST && cmd_q[7] |=> cmd_q[3:0] == PTR_ALL_FIRST;
    endproperty
    a_wrap_all: assert property (p_wrap_all) else $error("no wrap to zero at top");

    property p_wrap_bright;
        adv_w && cmd_q[7:5] == INCR_BRIGHT && cmd_q[3:0] == PTR_BRIGHT_LAST
            |=> cmd_q[3:0] == PTR_BRIGHT_FIRST;
    endproperty
    a_wrap_bright: assert property (p_wrap_bright) else $error("bad brightness wrap");

    property p_wrap_global;
        adv_w && cmd_q[7:5] == INCR_GLOBAL && cmd_q[3:0] == PTR_GLOBAL_LAST
            |=> cmd_q[3:0] == PTR_GLOBAL_FIRST;
    endproperty
    a_wrap_global: assert property (p_wrap_global) else $error("bad global wrap");

    property p_wrap_mixed;
        adv_w && cmd_q[7:5] == INCR_MIXED && cmd_q[3:0] == PTR_GLOBAL_LAST
            |=> cmd_q[3:0] == PTR_BRIGHT_FIRST;
    endproperty
    a_wrap_mixed: assert property (p_wrap_mixed) else $error("bad mixed wrap");

    property p_opt_keep;
        adv_w |=> $stable(cmd_q[7:4]);
    endproperty
    a_opt_keep: assert property (p_opt_keep) else $error("option bits changed");

    property p_srst_cmd;
        soft_reset_call |-> $stable(cmd_q) ##1 $stable(cmd_q);
    endproperty
    a_srst_cmd: assert property (p_srst_cmd) else $error("reset call touched command");

    property p_bad_ptr;
        state_q == ST_CMD && byte_end && shift_q[3:0] > PTR_LAST |=> !sda_oe && $stable(cmd_q);
    endproperty
    a_bad_ptr: assert property (p_bad_ptr) else $error("reserved pointer acknowledged");

    property p_step;
        adv_w && cmd_q[7] && cmd_q[3:0] < PTR_BRIGHT_LAST |=> cmd_q[3:0] == $past(cmd_q[3:0]) + 4'h1;
    endproperty
    a_step: assert property (p_step) else $error("pointer did not step by one");

    c_srst:  cover property (soft_reset_call);
    c_read:  cover property (state_q == ST_MACK && scl_fall && mack_q);
    c_wrap:  cover property (wr_end && cmd_q[7:5] == INCR_MIXED && cmd_q[3:0] == PTR_GLOBAL_LAST);

endmodule // lamp_addr_target

`default_nettype wire

// ### shared/lamp_addr_pkg.sv
// Constants and types for the serial target front end of the lamp driver
package lamp_addr_pkg;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_RST       = 8'h80;
    localparam logic [7:0] BCAST_RST     = 8'hE0;
    localparam logic [7:0] GRP1_RST      = 8'hE2;
    localparam logic [7:0] GRP2_RST      = 8'hE4;
    localparam logic [7:0] GRP3_RST      = 8'hE8;
    localparam logic [3:0] MODE1_EN_RST  = 4'h1;   // Broadcast on, groups off
    localparam logic [7:0] SOFT_RST_BYTE = 8'h06;  // Reset call with write direction

    // ------------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_MODE1 = 4'h0;
    localparam logic [3:0] IDX_GRP1  = 4'h9;
    localparam logic [3:0] IDX_GRP2  = 4'hA;
    localparam logic [3:0] IDX_GRP3  = 4'hB;
    localparam logic [3:0] IDX_BCAST = 4'hC;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int EN_GRP1_BIT  = 3;
    localparam int EN_GRP2_BIT  = 2;
    localparam int EN_GRP3_BIT  = 1;
    localparam int EN_BCAST_BIT = 0;
    localparam int SLEEP_BIT    = 4;

    // ------------------------------------------------------------------
    // Pointer windows and increment options
    // ------------------------------------------------------------------
    localparam logic [3:0] PTR_ALL_FIRST    = 4'h0;
    localparam logic [3:0] PTR_LAST         = 4'hC;
    localparam logic [3:0] PTR_BRIGHT_FIRST = 4'h2;
    localparam logic [3:0] PTR_BRIGHT_LAST  = 4'h5;
    localparam logic [3:0] PTR_GLOBAL_FIRST = 4'h6;
    localparam logic [3:0] PTR_GLOBAL_LAST  = 4'h7;
    localparam logic [2:0] INCR_ALL         = 3'h4;
    localparam logic [2:0] INCR_BRIGHT      = 3'h5;
    localparam logic [2:0] INCR_GLOBAL      = 3'h6;
    localparam logic [2:0] INCR_MIXED       = 3'h7;

    // Register write strobe towards the register file
    typedef struct packed {
        logic       strobe;
        logic [3:0] index;
        logic [7:0] data;
    } reg_wr_s;

endpackage

// ### tb/lamp_bus_ctl.sv
// Behavioural serial bus controller that drives the lamp target
`timescale 1ns/10ps
`default_nettype none

module lamp_bus_ctl (
    input  wire logic mclk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    // ------------------------------------------------
    // Bit level: data bits move only while scl is low; start and stop move it while scl is high
    // ------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Released data floats to the pull-up, never to a stale value
    task automatic put_bit(input logic b, output logic seen);
        sda_low = ~b;
        tick(1);
        scl = 1'b1;
        tick(3);
        seen = sda_line;
        tick(1);
        scl = 1'b0;
        tick(2);
    endtask

    task automatic start();
        sda_low = 1'b0;
        scl = 1'b1;
        tick(3);
        sda_low = 1'b1;
        tick(3);
        scl = 1'b0;
        tick(2);
    endtask

    task automatic stop();
        sda_low = 1'b1;
        tick(1);
        scl = 1'b1;
        tick(3);
        sda_low = 1'b0;
        tick(4);
    endtask

    // ------------------------------------------------
    // Byte level, MSB first, ninth bit is the acknowledge
    // ------------------------------------------------
    task automatic send(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(b[i], s);
        put_bit(1'b1, s);
        ack = ~s;
    endtask

    task automatic addr(input logic [6:0] a, input logic rd, output logic ack);
        send({a, rd}, ack);
    endtask

    // The last byte of a read is refused so the target lets go
    task automatic recv(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
        put_bit(last, s);
    endtask

    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
endmodule // lamp_bus_ctl
`default_nettype wire

// ### tb/led_driver_i2c_addr_pointer_tb_top.sv
// Self-checking bench for the lamp target address and pointer logic
`timescale 1ns/10ps
`default_nettype none

module led_driver_i2c_addr_pointer_tb_top;
    import lamp_addr_pkg::*;
    localparam logic [6:0] MY = {5'h18, 2'b10};
    logic mclk = 1'b0, resetn = 1'b0, scl, sda_low, sda_o, sda_oe, sda_line, srst;
    logic [3:0] rd_idx;
    logic [7:0] cmd, rdata, d;
    reg_wr_s    reg_wr;
    logic       ack;
    int         fails = 0, cmp_count = 0, sr_cnt = 0;
    logic [3:0] wq[$];
    logic [7:0] dq[$];

    always #50 mclk = ~mclk;
    assign sda_line = ~(sda_low | (sda_oe & ~sda_o));
    assign rdata = {4'h5, rd_idx};

    lamp_addr_target #(.TEN_PIN(1'b1), .ADDR_UPPER(5'h18)) lamp_addr_target_inst (
        .mclk(mclk), .resetn(resetn), .scl(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .hw_addr_select_pin_lo(1'b0), .hw_addr_select_pin_hi(1'b1),
        .reg_rdata(rdata), .reg_rd_index(rd_idx), .reg_wr(reg_wr),
        .command_pointer_register(cmd), .soft_reset_call(srst));
    lamp_bus_ctl lamp_bus_ctl_inst (.mclk(mclk), .sda_line(sda_line), .scl(scl),
        .sda_low(sda_low));

    // Log every register write and every reset call pulse; each pulse stands
    // one whole cycle, so the falling edge sees it once, clear of its launch edge
    always @(negedge mclk)
    begin
        if (reg_wr.strobe === 1'b1)
        begin
            wq.push_back(reg_wr.index);
            dq.push_back(reg_wr.data);
        end
        if (srst === 1'b1) sr_cnt++;
    end

    // ------------------------------------------------
    // Checking helpers
    // ------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    // Reference pointer step worked out from the window table
    function automatic logic [3:0] step(input logic [7:0] c, input logic [3:0] p);
        logic [3:0] lo, hi;
        lo = (c[6:5] == 2'b00) ? 4'h0 : (c[6:5] == 2'b10) ? 4'h6 : 4'h2;
        hi = (c[6:5] == 2'b00) ? 4'hC : (c[6:5] == 2'b01) ? 4'h5 : 4'h7;
        if (!c[7]) return p;
        if (p == hi) return lo;
        if (p == 4'hC) return 4'h0;
        return p + 4'h1;
    endfunction

    task automatic probe(input logic [7:0] a, input logic exp);
        lamp_bus_ctl_inst.start();
        lamp_bus_ctl_inst.addr(a[7:1], a[0], ack);
        check("address ack", {7'h0, exp}, {7'h0, ack});
        if (ack && a[0]) lamp_bus_ctl_inst.recv(1'b1, d);
        lamp_bus_ctl_inst.stop();
    endtask

    // Write a command byte and n data bytes, then compare write indices
    task automatic wr_seq(input logic [6:0] a, input logic [7:0] c, input int n,
                          input logic [7:0] v);
        logic [3:0] p;
        wq.delete();
        dq.delete();
        lamp_bus_ctl_inst.start();
        lamp_bus_ctl_inst.addr(a, 1'b0, ack);
        lamp_bus_ctl_inst.send(c, ack);
        check("command ack", 8'h01, {7'h0, ack});
        for (int i = 0; i < n; i++) lamp_bus_ctl_inst.send(v, ack);
        lamp_bus_ctl_inst.stop();
        // An empty queue would hand back zero and hide a missing strobe
        check("write count", n[7:0], 8'(wq.size()));
        p = c[3:0];
        for (int i = 0; i < n; i++)
        begin
            check("write index", {4'h0, p}, {4'h0, wq.pop_front()});
            check("write data", v, dq.pop_front());
            p = step(c, p);
        end
        check("command after", {c[7:4], p}, cmd);
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    logic [7:0] pb[12] = '{8'hC4, 8'hC5, 8'hC0, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4,
                           8'hE5, 8'hE8, 8'h06, 8'h07};
    logic       pa[12] = '{1, 1, 0, 1, 1, 0, 0, 0, 0, 0, 1, 0};
    logic [7:0] cl[5] = '{8'h8A, 8'hA3, 8'hC7, 8'hE8, 8'h05};
    int         cn[5] = '{6, 6, 4, 22, 3};

    initial
    begin
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        check("command reset", 8'h80, cmd);
        for (int i = 0; i < 12; i++) probe(pb[i], pa[i]);
        check("reset calls", 8'h01, sr_cnt[7:0]);
        // The two acknowledged probe reads stepped the pointer from 0 to 2
        check("command kept", 8'h82, cmd);
        lamp_bus_ctl_inst.start();
        lamp_bus_ctl_inst.addr(MY, 1'b0, ack);
        lamp_bus_ctl_inst.send(8'h0D, ack);
        lamp_bus_ctl_inst.stop();
        check("reserved pointer ack", 8'h00, {7'h0, ack});
        check("reserved pointer cmd", 8'h82, cmd);
        wr_seq(MY, 8'h00, 1, 8'h09);
        probe(8'hE2, 1'b1);
        wr_seq(MY, 8'h00, 1, 8'h08);
        probe(8'hE0, 1'b0);
        wr_seq(MY, 8'h00, 1, 8'h01);
        wr_seq(7'h70, 8'h85, 3, 8'h01);
        for (int i = 0; i < 5; i++) wr_seq(MY, cl[i], cn[i], 8'h01);
        wr_seq(MY, 8'hA4, 0, 8'h00);
        lamp_bus_ctl_inst.start();
        lamp_bus_ctl_inst.addr(MY, 1'b1, ack);
        lamp_bus_ctl_inst.recv(1'b0, d);
        check("read first", 8'h54, d);
        lamp_bus_ctl_inst.recv(1'b1, d);
        lamp_bus_ctl_inst.stop();
        check("read second", 8'h55, d);
        check("read pointer", 8'hA2, cmd);
        report_and_stop();
    end

    // Whole run needs under 8000 cycles; the limit leaves ample room
    initial
    begin
        repeat (40000) @(posedge mclk);
        fails++;
        report_and_stop();
    end
endmodule // led_driver_i2c_addr_pointer_tb_top
`default_nettype wire
